// ===== pbs_port.sv
// pin-level pipelined burst sram port: command decode, burst, data drive, test port
`timescale 1ns/100ps
module pbs_port import pbs_pkg::*; #(
	parameter int ADDR_W = PBS_ADDR_W,
	parameter int LANES = PBS_LANES
) (
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RST_N,
	// command
	input wire logic I_CLOCK_GATE_N,
	input wire logic I_CHIP_SELECT_FIRST_N,
	input wire logic I_CHIP_SELECT_SECOND,
	input wire logic I_CHIP_SELECT_THIRD_N,
	input wire logic I_WRITE_N,
	input wire logic I_LOAD_OR_ADVANCE,
	input wire logic [ADDR_W-1:0] I_ADDR,
	input wire logic [LANES-1:0] I_BYTE_LANE_SELECT_N,
	input wire logic I_OE_N,
	// data and parity lanes
	input wire logic [LANES*PBS_LANE_DATA_W-1:0] I_DQ,
	input wire logic [LANES-1:0] I_PARITY_LANES,
	output logic [LANES*PBS_LANE_DATA_W-1:0] O_DQ,
	output logic [LANES-1:0] O_PARITY_LANES,
	output logic O_DQ_OE,
	// burst order strap
	input wire logic I_BURST_ORDER,
	input wire logic I_BURST_ORDER_TIED,
	// test port
	input wire logic I_TEST_CLOCK,
	input wire logic I_TDI,
	output logic O_TDO
);
	localparam int LANE_W = PBS_LANE_DATA_W + 1;
	localparam int WORD_W = LANES * LANE_W;

	generate
		if (ADDR_W < PBS_BURST_W + 1 || LANES < 1) begin : g_bad_param
			$error("pbs_port: address width or lane count too small");
		end
	endgenerate

	logic en;
	logic sel;
	logic load;
	pbs_op_t op_reg, op_next;
	logic [ADDR_W-1:0] base_reg, base_next;
	logic [PBS_BURST_W-1:0] cnt_reg, cnt_next;
	logic [LANES-1:0] bw_reg, bw_next;
	logic rd2_reg, rd2_next;
	logic drive_reg, drive_next;
	logic oe_reg, oe_next;
	logic [LANES*PBS_LANE_DATA_W-1:0] dq_reg, dq_next;
	logic [LANES-1:0] dqp_reg, dqp_next;
	logic order_reg, order_next;
	logic caught_reg, caught_next;
	logic tck_prev_reg;
	logic tdi_reg, tdi_next;
	logic tdo_reg, tdo_next;
	pbs_edge_t tck_edge;
	logic [ADDR_W-1:0] cur_addr, next_addr;
	logic [WORD_W-1:0] wr_word, rd_word;
	logic [LANES*PBS_LANE_DATA_W-1:0] rd_dq;
	logic [LANES-1:0] rd_dqp;
	logic wr_en, rd_en;

	////////////////////////////////////////////////////////////////
	// qualification and selection
	assign en = !I_CLOCK_GATE_N;
	assign sel = !I_CHIP_SELECT_FIRST_N && I_CHIP_SELECT_SECOND && !I_CHIP_SELECT_THIRD_N;
	assign load = !I_LOAD_OR_ADVANCE;

	////////////////////////////////////////////////////////////////
	// command and burst counter
	always_comb begin
		op_next = op_reg;
		base_next = base_reg;
		cnt_next = cnt_reg;
		bw_next = bw_reg;
		if (en) begin
			if (load) begin
				if (sel) begin
					op_next = '{valid: 1'b1, write: !I_WRITE_N};
					base_next = I_ADDR;
					cnt_next = PBS_BURST_START;
				end else begin
					op_next = PBS_OP_IDLE;
				end
			end else begin
				cnt_next = cnt_reg + PBS_BURST_STEP;
			end
			bw_next = ~I_BYTE_LANE_SELECT_N & {LANES{!op_next.write ? 1'b0 : 1'b1}};
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			op_reg <= PBS_OP_IDLE;
			base_reg <= '0;
			cnt_reg <= PBS_BURST_START;
			bw_reg <= '0;
		end else begin
			op_reg <= op_next;
			base_reg <= base_next;
			cnt_reg <= cnt_next;
			bw_reg <= bw_next;
		end
	end

	assign cur_addr = {base_reg[ADDR_W-1:PBS_BURST_W],
		pbs_burst_lo(order_reg, base_reg[PBS_BURST_W-1:0], cnt_reg)};
	assign next_addr = {base_next[ADDR_W-1:PBS_BURST_W],
		pbs_burst_lo(order_reg, base_next[PBS_BURST_W-1:0], cnt_next)};

	////////////////////////////////////////////////////////////////
	// memory and lane packing
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_pack
			assign wr_word[g*LANE_W +: LANE_W] = {I_PARITY_LANES[g],
				I_DQ[g*PBS_LANE_DATA_W +: PBS_LANE_DATA_W]};
			assign rd_dqp[g] = rd_word[g*LANE_W + PBS_LANE_DATA_W];
			assign rd_dq[g*PBS_LANE_DATA_W +: PBS_LANE_DATA_W] =
				rd_word[g*LANE_W +: PBS_LANE_DATA_W];
		end
	endgenerate

	assign wr_en = en && op_reg.valid && op_reg.write;
	assign rd_en = en && op_next.valid && !op_next.write;

	pbs_mem #(
		.ADDR_W(ADDR_W),
		.LANES(LANES),
		.LANE_W(LANE_W)
	) u_mem (
		.i_clk(I_CLOCK),
		.i_rst_n(I_RST_N),
		.i_wr_en(wr_en),
		.i_wr_addr(cur_addr),
		.i_wr_data(wr_word),
		.i_wr_be(bw_reg),
		.i_rd_en(rd_en),
		.i_rd_addr(next_addr),
		.o_rd_data(rd_word)
	);

	////////////////////////////////////////////////////////////////
	// output data and drive
	always_comb begin
		rd2_next = rd2_reg;
		drive_next = drive_reg;
		dq_next = dq_reg;
		dqp_next = dqp_reg;
		if (en) begin
			rd2_next = rd_en;
			drive_next = rd2_reg;
			if (rd2_reg) begin
				dq_next = rd_dq;
				dqp_next = rd_dqp;
			end
		end
		oe_next = drive_next && !I_OE_N;
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rd2_reg <= 1'b0;
			drive_reg <= 1'b0;
			oe_reg <= 1'b0;
			dq_reg <= '0;
			dqp_reg <= '0;
		end else begin
			rd2_reg <= rd2_next;
			drive_reg <= drive_next;
			oe_reg <= oe_next;
			dq_reg <= dq_next;
			dqp_reg <= dqp_next;
		end
	end

	assign O_DQ = dq_reg;
	assign O_PARITY_LANES = dqp_reg;
	assign O_DQ_OE = oe_reg;

	////////////////////////////////////////////////////////////////
	// burst order strap, caught once after reset release
	always_comb begin
		order_next = order_reg;
		caught_next = 1'b1;
		if (!caught_reg) begin
			order_next = I_BURST_ORDER_TIED ? I_BURST_ORDER : PBS_ORDER_INTERLEAVED;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			order_reg <= PBS_ORDER_INTERLEAVED;
			caught_reg <= 1'b0;
		end else begin
			order_reg <= order_next;
			caught_reg <= caught_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// test port serial stage
	assign tck_edge = '{rise: I_TEST_CLOCK && !tck_prev_reg, fall: !I_TEST_CLOCK && tck_prev_reg};

	always_comb begin
		tdi_next = tck_edge.rise ? I_TDI : tdi_reg;
		tdo_next = tck_edge.fall ? tdi_reg : tdo_reg;
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			tck_prev_reg <= 1'b0;
			tdi_reg <= 1'b0;
			tdo_reg <= 1'b0;
		end else begin
			tck_prev_reg <= I_TEST_CLOCK;
			tdi_reg <= tdi_next;
			tdo_reg <= tdo_next;
		end
	end

	assign O_TDO = tdo_reg;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_RST_N);

	sequence s_read_cmd;
		en && load && sel && I_WRITE_N && !I_OE_N;
	endsequence

	sequence s_deselect_cmd;
		en && load && !sel;
	endsequence

	a_gate_hold_data: assert property (I_CLOCK_GATE_N |=> $stable(O_DQ) && $stable(op_reg))
		else $error("data or state changed on a gated edge");
	a_oe_high_float: assert property (I_OE_N |=> !O_DQ_OE)
		else $error("pins driven with output enable high");
	a_write_data_float: assert property (wr_en |=> !O_DQ_OE)
		else $error("pins driven in a write data cycle");
	a_deselect_float: assert property (s_deselect_cmd ##1 en |=> !O_DQ_OE)
		else $error("pins driven after deselect");
	a_read_latency: assert property (s_read_cmd ##1 (en && !I_OE_N) |=> O_DQ_OE)
		else $error("read data not driven one cycle later");
	a_first_select: assert property (en && load && I_CHIP_SELECT_FIRST_N |=> !op_reg.valid)
		else $error("selected with first select high");
	a_second_select: assert property (en && load && !I_CHIP_SELECT_SECOND |=> !op_reg.valid)
		else $error("selected with second select low");
	a_third_select: assert property (en && load && I_CHIP_SELECT_THIRD_N |=> !op_reg.valid)
		else $error("selected with third select high");
	a_burst_step: assert property (en && !load |=> cnt_reg == $past(cnt_reg) + PBS_BURST_STEP)
		else $error("burst counter did not advance");
	a_tdo_on_fall: assert property (!$stable(O_TDO) |-> $past(tck_prev_reg && !I_TEST_CLOCK))
		else $error("serial output changed off a falling edge");
	a_strap_float: assert property ($rose(caught_reg) && $past(!I_BURST_ORDER_TIED) |-> order_reg)
		else $error("untied strap not interleaved");
endmodule

// ===== pbs_pkg.sv
// constants, types and burst order helper for the pipelined burst sram port
package pbs_pkg;
	localparam int PBS_ADDR_W = 18;
	localparam int PBS_LANES = 4;
	localparam int PBS_LANE_DATA_W = 8;
	localparam int PBS_BURST_W = 2;
	localparam logic PBS_ORDER_INTERLEAVED = 1'b1;
	localparam logic PBS_ORDER_LINEAR = 1'b0;
	localparam logic [PBS_BURST_W-1:0] PBS_BURST_START = 2'h0;
	localparam logic [PBS_BURST_W-1:0] PBS_BURST_STEP = 2'h1;

	typedef struct packed {
		logic valid;
		logic write;
	} pbs_op_t;

	localparam pbs_op_t PBS_OP_IDLE = '{valid: 1'b0, write: 1'b0};

	typedef struct packed {
		logic rise;
		logic fall;
	} pbs_edge_t;

	// low address bits of the current beat of a burst
	function automatic logic [PBS_BURST_W-1:0] pbs_burst_lo(
		input logic order,
		input logic [PBS_BURST_W-1:0] base,
		input logic [PBS_BURST_W-1:0] cnt
	);
		pbs_burst_lo = (order == PBS_ORDER_INTERLEAVED) ? (base ^ cnt) : (base + cnt);
	endfunction
endpackage

// ===== pbs_mem.sv
// byte-lane writable memory with registered read data
`timescale 1ns/100ps
module pbs_mem import pbs_pkg::*; #(
	parameter int ADDR_W = PBS_ADDR_W,
	parameter int LANES = PBS_LANES,
	parameter int LANE_W = PBS_LANE_DATA_W + 1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// write side
	input wire logic i_wr_en,
	input wire logic [ADDR_W-1:0] i_wr_addr,
	input wire logic [LANES*LANE_W-1:0] i_wr_data,
	input wire logic [LANES-1:0] i_wr_be,
	// read side
	input wire logic i_rd_en,
	input wire logic [ADDR_W-1:0] i_rd_addr,
	output logic [LANES*LANE_W-1:0] o_rd_data
);
	logic [LANES*LANE_W-1:0] rd_word;
	logic [LANES*LANE_W-1:0] rd_next;

	////////////////////////////////////////////////////////////////
	// lane writes, one array per lane so each has a single writer
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic [LANE_W-1:0] mem [0:(1<<ADDR_W)-1];
			always_ff @(posedge i_clk) begin
				if (i_wr_en && i_wr_be[g]) begin
					mem[i_wr_addr] <= i_wr_data[g*LANE_W +: LANE_W];
				end
			end
			assign rd_word[g*LANE_W +: LANE_W] = mem[i_rd_addr];
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// registered read
	always_comb begin
		rd_next = o_rd_data;
		if (i_rd_en) begin
			rd_next = rd_word;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_data <= '0;
		end else begin
			o_rd_data <= rd_next;
		end
	end
endmodule

// ===== pbs_ctrl_model.sv
// memory controller model driving the sram command, data and strap pins
`timescale 1ns/100ps
module pbs_ctrl_model import pbs_pkg::*; (
	// clock
	input wire logic i_clk,
	// command
	output logic o_gate_n,
	output logic [2:0] o_sel,
	output logic o_write_n,
	output logic o_adv,
	output logic [PBS_ADDR_W-1:0] o_addr,
	output logic [PBS_LANES-1:0] o_be_n,
	output logic o_oe_n,
	// data and strap
	output logic [PBS_LANES*9-1:0] o_data,
	output logic o_order,
	output logic o_tied
);
	initial begin
		o_gate_n = 1'b0;
		o_sel = 3'h5;
		o_write_n = 1'b1;
		o_adv = 1'b0;
		o_addr = '0;
		o_be_n = 4'hf;
		o_oe_n = 1'b0;
		o_data = '0;
		o_order = 1'b1;
		o_tied = 1'b1;
	end
	////////////////////////////////////////
	// one bus cycle; released data lines show the inverse of the last value
	task automatic cmd(input logic g, input logic [2:0] s, input logic wn, input logic adv,
		input logic [PBS_ADDR_W-1:0] a, input logic [PBS_LANES-1:0] be,
		input logic [PBS_LANES*9-1:0] d, input logic dv);
		@(posedge i_clk);
		o_gate_n <= g;
		o_sel <= s;
		o_write_n <= wn;
		o_adv <= adv;
		o_addr <= a;
		o_be_n <= be;
		o_data <= dv ? d : ~o_data;
	endtask
	task automatic oe(input logic v);
		o_oe_n <= v;
	endtask
	// strap only changes while the device is held in reset
	task automatic strap(input logic m, input logic t);
		o_order <= m;
		o_tied <= t;
	endtask
endmodule

// ===== tb_pbs_port.sv
// self-checking bench for the pipelined burst sram port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tb_pbs_port;
	import pbs_pkg::*;
	localparam logic [2:0] SEL = 3'h2;
	localparam logic [2:0] IDL = 3'h5;
	logic clk, rst_n, tck, tdi, b, pb;
	logic gate_n, wn, adv, oe_n, order, tied, oe, tdo;
	logic [2:0] sel;
	logic [PBS_ADDR_W-1:0] addr;
	logic [PBS_LANES-1:0] be_n, par_o;
	logic [PBS_LANES*9-1:0] data, e;
	logic [PBS_LANES*8-1:0] dq_o;
	logic [PBS_LANES*9-1:0] ref_m [int];
	logic [PBS_LANES*9-1:0] exp_q [$];
	logic [PBS_LANES*9:0] prev;
	int error_cnt = 0;
	int tests_run = 0;
	pbs_ctrl_model u_ctl (.i_clk(clk), .o_gate_n(gate_n), .o_sel(sel), .o_write_n(wn),
		.o_adv(adv), .o_addr(addr), .o_be_n(be_n), .o_oe_n(oe_n), .o_data(data),
		.o_order(order), .o_tied(tied));
	pbs_port uut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_CLOCK_GATE_N(gate_n),
		.I_CHIP_SELECT_FIRST_N(sel[2]), .I_CHIP_SELECT_SECOND(sel[1]),
		.I_CHIP_SELECT_THIRD_N(sel[0]), .I_WRITE_N(wn), .I_LOAD_OR_ADVANCE(adv),
		.I_ADDR(addr), .I_BYTE_LANE_SELECT_N(be_n), .I_OE_N(oe_n), .I_DQ(data[31:0]),
		.I_PARITY_LANES(data[35:32]), .O_DQ(dq_o), .O_PARITY_LANES(par_o), .O_DQ_OE(oe),
		.I_BURST_ORDER(order), .I_BURST_ORDER_TIED(tied), .I_TEST_CLOCK(tck), .I_TDI(tdi),
		.O_TDO(tdo));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic summarize();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	////////////////////////////////////////
	// watcher: gated edges hold, enabled driving edges take the oldest note
	initial begin
		logic g;
		prev = '0;
		forever begin
			@(posedge clk);
			g = gate_n;
			#1;
			if (rst_n === 1'b1 && g === 1'b1) begin
				`CHK("held outputs", prev, {oe, par_o, dq_o})
			end else if (rst_n === 1'b1 && oe === 1'b1) begin
				e = exp_q.size() ? exp_q.pop_front() : 'x;
				`CHK("read data", e, {par_o, dq_o})
			end
			prev = {oe, par_o, dq_o};
		end
	end
	////////////////////////////////////////
	task automatic idle(input int n);
		repeat (n) u_ctl.cmd(1'b0, IDL, 1'b1, 1'b0, '0, 4'hf, '0, 1'b0);
	endtask
	task automatic wr(input logic [PBS_ADDR_W-1:0] a, input logic [3:0] be, input logic [2:0] s);
		logic [PBS_LANES*9-1:0] d, m;
		d = 36'({$urandom(), $urandom()});
		u_ctl.cmd(1'b0, s, 1'b0, 1'b0, a, be, '0, 1'b0);
		u_ctl.cmd(1'b0, IDL, 1'b1, 1'b0, '0, 4'hf, d, 1'b1);
		if (s == SEL) begin
			m = ref_m.exists(a) ? ref_m[a] : '0;
			for (int g = 0; g < PBS_LANES; g++) begin
				if (!be[g]) begin
					m[g*8 +: 8] = d[g*8 +: 8];
					m[32+g] = d[32+g];
				end
			end
			ref_m[a] = m;
		end
	endtask
	task automatic rd(input logic [PBS_ADDR_W-1:0] a);
		u_ctl.cmd(1'b0, SEL, 1'b1, 1'b0, a, 4'hf, '0, 1'b0);
		exp_q.push_back(ref_m[a]);
	endtask
	task automatic do_reset(input logic m, input logic t);
		u_ctl.strap(m, t);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		idle(2);
	endtask
	// five beats from base 1, advancing with selects dropped, last beat wraps
	task automatic burst(input logic il);
		logic [1:0] lo;
		for (int k = 0; k < 4; k++) wr({16'h0123, 2'(k)}, 4'h0, SEL);
		idle(1);
		for (int k = 0; k < 5; k++) begin
			lo = il ? (2'h1 ^ 2'(k)) : (2'h1 + 2'(k));
			u_ctl.cmd(1'b0, k ? IDL : SEL, 1'b1, k != 0, {16'h0123, 2'h1}, 4'hf, '0, 1'b0);
			exp_q.push_back(ref_m[{16'h0123, lo}]);
		end
		idle(3);
	endtask
	////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		tck = 1'b0;
		tdi = 1'b0;
		pb = 1'b0;
		void'($urandom(25929));
		do_reset(1'b1, 1'b1);
		burst(1'b1);
		do_reset(1'b0, 1'b1);
		burst(1'b0);
		do_reset(1'b0, 1'b0);
		burst(1'b1);
		wr(18'h00010, 4'h0, SEL);
		wr(18'h00010, 4'ha, SEL);
		wr(18'h00010, 4'h0, 3'h6);
		wr(18'h00010, 4'h0, 3'h0);
		wr(18'h00010, 4'h0, 3'h3);
		wr(18'h00020, 4'h0, SEL);
		idle(1);
		rd(18'h00010);
		wr(18'h00030, 4'h0, SEL);
		rd(18'h00020);
		idle(2);
		rd(18'h00020);
		u_ctl.oe(1'b1);
		void'(exp_q.pop_back());
		idle(3);
		u_ctl.oe(1'b0);
		rd(18'h00010);
		idle(1);
		repeat (3) u_ctl.cmd(1'b1, SEL, 1'b1, 1'b0, 18'h00030, 4'hf, '0, 1'b0);
		rd(18'h00030);
		idle(3);
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			b = 1'($urandom());
			tdi <= b;
			repeat (4) @(posedge clk);
			tck <= 1'b1;
			repeat (4) @(posedge clk);
			tdi <= ~b;
			#1;
			`CHK("tdo before fall", pb, tdo)
			repeat (4) @(posedge clk);
			tck <= 1'b0;
			repeat (4) @(posedge clk);
			#1;
			`CHK("tdo after fall", b, tdo)
			pb = b;
		end
		`CHK("notes left", 0, exp_q.size())
		summarize();
	end
endmodule
